// *** rtl/svc_map.svh ***
// Register offsets, field positions, reset values and timing counts of the synthesizer control
`ifndef SVC_MAP_SVH
`define SVC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SVC_REG_TRIGGER 4'h0
`define SVC_REG_FEEDBACK 4'h1
`define SVC_REG_REFDIV 4'h2
`define SVC_REG_PUMP 4'h3
`define SVC_REG_OSC 4'h4
`define SVC_REG_OUTDIV 4'h5
`define SVC_REG_OUTPUT 4'h6
`define SVC_REG_STATUS 4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SVC_TRIG_SKIP 0
`define SVC_REFDIV_DOUBLER 12
`define SVC_PUMP_DLY_LSB 8
`define SVC_OSC_POLICY 2
`define SVC_OSC_BAND_LSB 8
`define SVC_OSC_RATE_LSB 16
`define SVC_OUTDIV_ZDLY 8
`define SVC_OUTDIV_MUXA 9
`define SVC_OUTDIV_MUXB 10
`define SVC_OUT_PDA 0
`define SVC_OUT_PDB 1
`define SVC_OUT_OVR 2
`define SVC_OUT_LVLA_LSB 8
`define SVC_OUT_LVLB_LSB 16

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SVC_RST_FEEDBACK 16'h0010
`define SVC_RST_REFDIV 8'h01
`define SVC_RST_BAND 8'h80
`define SVC_RST_CORE 2'h2
`define SVC_RST_DIV 6'h02
`define SVC_RST_LEVEL 6'h0F
`define SVC_DIV_MIN 6'h02
`define SVC_DIV_MAX 6'h26
`define SVC_BAND_LAST 8'hFF
`define SVC_CORE_LAST 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SVC_CLK_PERIOD_NS 8
`define SVC_PULSE_STEP_NS 8
`define SVC_PULSE_STEP_CYC ((`SVC_PULSE_STEP_NS + `SVC_CLK_PERIOD_NS - 1) / `SVC_CLK_PERIOD_NS)
`define SVC_SETTLE_NS 64
`define SVC_SETTLE_CYC (`SVC_SETTLE_NS / `SVC_CLK_PERIOD_NS)

`endif

// *** rtl/svc_pkg.sv ***
// Types shared by the synthesizer control modules
`default_nettype none
package svc_pkg;
	typedef enum logic [1:0] {SVC_CAL_IDLE, SVC_CAL_SETTLE, SVC_CAL_COMPARE, SVC_CAL_DONE} svc_cal_t;
	typedef enum logic [1:0] {SVC_PD_IDLE, SVC_PD_UP, SVC_PD_DOWN} svc_pd_t;
endpackage
`default_nettype wire

// *** rtl/svc_phase_det.sv ***
// Phase detector and charge pump pulse control
`include "svc_map.svh"
`default_nettype none
module svc_phase_det
	import svc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ref_edge,
	input wire logic fb_edge,
	input wire logic [2:0] pump_min_pulse_delay,
	output logic pump_up,
	output logic pump_down
);
	svc_pd_t state_q;
	logic [4:0] width_q;
	logic [4:0] min_cyc;

	assign min_cyc = 5'(({2'h0, pump_min_pulse_delay} + 5'h1) * `SVC_PULSE_STEP_CYC);

	// ----------------------------------------
	// Edge compare
	// ----------------------------------------
	// Coincident edges still give a short pulse both ways, as a real detector does
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SVC_PD_IDLE;
			width_q <= 5'h00;
		end else begin
			unique case (state_q)
				SVC_PD_IDLE: begin
					width_q <= 5'h00;
					if (ref_edge && !fb_edge) begin
						state_q <= SVC_PD_UP;
					end else if (fb_edge && !ref_edge) begin
						state_q <= SVC_PD_DOWN;
					end
				end
				SVC_PD_UP, SVC_PD_DOWN: begin
					if (width_q != 5'h1F) begin
						width_q <= width_q + 5'h01;
					end
					// Error ends on the lagging edge or at a width count of 31, but never before the minimum time
					if ((state_q == SVC_PD_UP ? fb_edge : ref_edge) || width_q == 5'h1F) begin
						state_q <= SVC_PD_IDLE;
					end
				end
				default: state_q <= SVC_PD_IDLE;
			endcase
		end
	end

	logic stretch_q;
	logic [4:0] hold_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 5'h00;
			stretch_q <= 1'b0;
		end else if (state_q == SVC_PD_IDLE && (ref_edge || fb_edge)) begin
			hold_q <= min_cyc;
			stretch_q <= 1'b1;
		end else if (hold_q != 5'h00) begin
			hold_q <= hold_q - 5'h01;
		end else begin
			stretch_q <= 1'b0;
		end
	end

	assign pump_up = state_q == SVC_PD_UP || (stretch_q && hold_q != 5'h00);
	assign pump_down = state_q == SVC_PD_DOWN || (stretch_q && hold_q != 5'h00);

	pump_min_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(stretch_q) |-> (pump_up && pump_down))
		else $error("pump minimum pulse missing");
endmodule
`default_nettype wire

// *** rtl/svc_out_div.sv ***
// Even output divider for the two RF ports
`include "svc_map.svh"
`default_nettype none
module svc_out_div
	import svc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic osc_clk_in,
	input wire logic [5:0] output_divide_ratio,
	output logic div_out
);
	logic [4:0] cnt_q;
	logic [4:0] half;

	// Only even ratios exist, so half the ratio sets the toggle period
	assign half = output_divide_ratio[5:1];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
			div_out <= 1'b0;
		end else if (osc_clk_in) begin
			if (cnt_q + 5'h01 >= half) begin
				cnt_q <= 5'h00;
				div_out <= ~div_out;
			end else begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	div_even_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		output_divide_ratio[0] == 1'b0 && output_divide_ratio >= `SVC_DIV_MIN
		&& output_divide_ratio <= `SVC_DIV_MAX)
		else $error("odd or out of range divide ratio");
endmodule
`default_nettype wire

// *** rtl/svc_synth_ctrl.sv ***
// Synthesizer control top: registers, calibration, divider routing, output power
//
// Chosen here: the placing of the registers and the strobed register port.
`include "svc_map.svh"
`default_nettype none
module svc_synth_ctrl
	import svc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ref_div_pulse,
	input wire logic fb_div_pulse,
	input wire logic osc_tick,
	input wire logic osc_above_target,
	input wire logic osc_at_target,
	input wire logic output_gate_pin,
	output logic pump_up,
	output logic pump_down,
	output logic [4:0] pump_gain_word,
	output logic [1:0] core_active,
	output logic [7:0] band_active,
	output logic rf_port_a,
	output logic rf_port_b,
	output logic rf_port_a_on,
	output logic rf_port_b_on,
	output logic [5:0] rf_port_a_level,
	output logic [5:0] rf_port_b_level,
	output logic loop_locked,
	output logic fb_through_divider
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic ref_s_q;
	logic fb_s_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			ref_s_q <= 1'b0;
			fb_s_q <= 1'b0;
		end else begin
			sync1_q <= {output_gate_pin, osc_at_target, osc_above_target, fb_div_pulse, ref_div_pulse};
			sync2_q <= sync1_q;
			ref_s_q <= sync2_q[0];
			fb_s_q <= sync2_q[1];
		end
	end
	logic ref_edge;
	logic fb_edge;
	logic above_s;
	logic at_s;
	logic gate_s;
	assign ref_edge = sync2_q[0] && !ref_s_q;
	assign fb_edge = sync2_q[1] && !fb_s_q;
	assign above_s = sync2_q[2];
	assign at_s = sync2_q[3];
	assign gate_s = sync2_q[4];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] feedback_n_q;
	logic [7:0] ref_div_q;
	logic reference_doubler_q;
	logic [2:0] pump_dly_q;
	logic [4:0] gain_q;
	logic [1:0] core_select_q;
	logic core_start_policy_q;
	logic [7:0] band_start_code_q;
	logic [7:0] reference_rate_setting_q;
	logic [5:0] div_ratio_q;
	logic zero_delay_enable_q;
	logic src_a_q;
	logic src_b_q;
	logic pd_a_q;
	logic pd_b_q;
	logic override_q;
	logic [5:0] level_a_q;
	logic [5:0] level_b_q;
	logic skip_cal_q;
	logic wr_trig;
	logic wr_fb;

	assign wr_trig = reg_wr && reg_addr == `SVC_REG_TRIGGER;
	assign wr_fb = reg_wr && reg_addr == `SVC_REG_FEEDBACK;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_cal_q <= 1'b0;
			feedback_n_q <= `SVC_RST_FEEDBACK;
			ref_div_q <= `SVC_RST_REFDIV;
			reference_doubler_q <= 1'b0;
			pump_dly_q <= 3'h0;
			gain_q <= 5'h00;
			core_select_q <= `SVC_RST_CORE;
			core_start_policy_q <= 1'b1;
			band_start_code_q <= `SVC_RST_BAND;
			reference_rate_setting_q <= 8'h00;
			div_ratio_q <= `SVC_RST_DIV;
			zero_delay_enable_q <= 1'b0;
			src_a_q <= 1'b0;
			src_b_q <= 1'b0;
			pd_a_q <= 1'b1;
			pd_b_q <= 1'b1;
			override_q <= 1'b0;
			level_a_q <= `SVC_RST_LEVEL;
			level_b_q <= `SVC_RST_LEVEL;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`SVC_REG_TRIGGER: skip_cal_q <= reg_wdata[`SVC_TRIG_SKIP];
				`SVC_REG_FEEDBACK: feedback_n_q <= reg_wdata[15:0];
				`SVC_REG_REFDIV: begin
					ref_div_q <= reg_wdata[7:0];
					reference_doubler_q <= reg_wdata[`SVC_REFDIV_DOUBLER];
				end
				`SVC_REG_PUMP: begin
					gain_q <= reg_wdata[4:0];
					pump_dly_q <= reg_wdata[`SVC_PUMP_DLY_LSB +: 3];
				end
				`SVC_REG_OSC: begin
					core_select_q <= reg_wdata[1:0];
					core_start_policy_q <= reg_wdata[`SVC_OSC_POLICY];
					band_start_code_q <= reg_wdata[`SVC_OSC_BAND_LSB +: 8];
					reference_rate_setting_q <= reg_wdata[`SVC_OSC_RATE_LSB +: 8];
				end
				`SVC_REG_OUTDIV: begin
					// Odd or out-of-range ratios are ignored
					if (!reg_wdata[0] && reg_wdata[5:0] >= `SVC_DIV_MIN
						&& reg_wdata[5:0] <= `SVC_DIV_MAX) begin
						div_ratio_q <= reg_wdata[5:0];
					end
					zero_delay_enable_q <= reg_wdata[`SVC_OUTDIV_ZDLY];
					src_a_q <= reg_wdata[`SVC_OUTDIV_MUXA];
					src_b_q <= reg_wdata[`SVC_OUTDIV_MUXB];
				end
				`SVC_REG_OUTPUT: begin
					pd_a_q <= reg_wdata[`SVC_OUT_PDA];
					pd_b_q <= reg_wdata[`SVC_OUT_PDB];
					override_q <= reg_wdata[`SVC_OUT_OVR];
					level_a_q <= reg_wdata[`SVC_OUT_LVLA_LSB +: 6];
					level_b_q <= reg_wdata[`SVC_OUT_LVLB_LSB +: 6];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Phase detector rate and loop
	// ----------------------------------------
	// Doubler gives two compare slots per reference pulse, one on each edge; R counts them down
	logic [7:0] rdiv_cnt_q;
	logic pd_ref_pulse;
	logic ref_slot;
	assign ref_slot = ref_edge || (reference_doubler_q && !sync2_q[0] && ref_s_q);
	assign pd_ref_pulse = ref_slot && (rdiv_cnt_q + 8'h01 >= ref_div_q);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdiv_cnt_q <= 8'h00;
		end else if (ref_slot) begin
			rdiv_cnt_q <= pd_ref_pulse ? 8'h00 : rdiv_cnt_q + 8'h01;
		end
	end

	svc_phase_det u_pd (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ref_edge(pd_ref_pulse),
		.fb_edge(fb_edge),
		.pump_min_pulse_delay(pump_dly_q),
		.pump_up(pump_up),
		.pump_down(pump_down)
	);
	assign pump_gain_word = gain_q;

	// ----------------------------------------
	// Frequency calibration
	// ----------------------------------------
	svc_cal_t cal_q;
	logic [1:0] core_q;
	logic [1:0] last_core_q;
	logic [7:0] band_q;
	logic [3:0] settle_q;
	logic cal_fail_q;
	logic cal_start;
	assign cal_start = wr_trig && !reg_wdata[`SVC_TRIG_SKIP];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_q <= SVC_CAL_IDLE;
			core_q <= `SVC_RST_CORE;
			band_q <= `SVC_RST_BAND;
			settle_q <= 4'h0;
			cal_fail_q <= 1'b0;
		end else if (cal_start) begin
			// Policy 1 starts at the selected core, else at the last core used
			core_q <= core_start_policy_q ? core_select_q : last_core_q;
			band_q <= band_start_code_q;
			settle_q <= 4'(`SVC_SETTLE_CYC);
			cal_fail_q <= 1'b0;
			cal_q <= SVC_CAL_SETTLE;
		end else begin
			unique case (cal_q)
				SVC_CAL_IDLE: begin
				end
				SVC_CAL_SETTLE: begin
					if (settle_q != 4'h0) begin
						settle_q <= settle_q - 4'h1;
					end else if (osc_tick) begin
						cal_q <= SVC_CAL_COMPARE;
					end
				end
				SVC_CAL_COMPARE: begin
					settle_q <= 4'(`SVC_SETTLE_CYC);
					cal_q <= SVC_CAL_SETTLE;
					if (at_s) begin
						cal_q <= SVC_CAL_DONE;
					end else if (above_s ? band_q == `SVC_BAND_LAST : band_q == 8'h00) begin
						// Band range exhausted: higher bands go down, lower cores go up
						if (above_s ? core_q == 2'h0 : core_q == `SVC_CORE_LAST) begin
							cal_fail_q <= 1'b1;
							cal_q <= SVC_CAL_DONE;
						end else begin
							core_q <= above_s ? core_q - 2'h1 : core_q + 2'h1;
							band_q <= band_start_code_q;
						end
					end else begin
						// Larger code lowers frequency
						band_q <= above_s ? band_q + 8'h01 : band_q - 8'h01;
					end
				end
				SVC_CAL_DONE: cal_q <= SVC_CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_core_q <= `SVC_RST_CORE;
		end else if (cal_q == SVC_CAL_DONE) begin
			last_core_q <= core_q;
		end
	end
	assign core_active = core_q;
	assign band_active = band_q;

	// ----------------------------------------
	// Zero delay and lock
	// ----------------------------------------
	logic locked_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			locked_q <= 1'b0;
		end else if (reg_wr && reg_addr == `SVC_REG_OUTDIV && reg_wdata[`SVC_OUTDIV_ZDLY]
			&& !zero_delay_enable_q) begin
			locked_q <= 1'b0;
		end else if (wr_fb || (cal_q == SVC_CAL_DONE && !cal_fail_q)) begin
			locked_q <= 1'b1;
		end else if (cal_start) begin
			locked_q <= 1'b0;
		end
	end
	assign loop_locked = locked_q;
	assign fb_through_divider = zero_delay_enable_q;

	// ----------------------------------------
	// Output divider and buffers
	// ----------------------------------------
	logic div_clk;
	svc_out_div u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.osc_clk_in(osc_tick),
		.output_divide_ratio(div_ratio_q),
		.div_out(div_clk)
	);

	logic on_a;
	logic on_b;
	assign on_a = !pd_a_q && (!override_q || gate_s);
	assign on_b = !pd_b_q && (!override_q || gate_s);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rf_port_a <= 1'b0;
			rf_port_b <= 1'b0;
			rf_port_a_on <= 1'b0;
			rf_port_b_on <= 1'b0;
			rf_port_a_level <= 6'h00;
			rf_port_b_level <= 6'h00;
		end else begin
			// Source select 1 bypasses the divider for that port
			rf_port_a <= on_a && (src_a_q ? osc_tick : div_clk);
			rf_port_b <= on_b && (src_b_q ? osc_tick : div_clk);
			rf_port_a_on <= on_a;
			rf_port_b_on <= on_b;
			rf_port_a_level <= on_a ? level_a_q : 6'h00;
			rf_port_b_level <= on_b ? level_b_q : 6'h00;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SVC_REG_TRIGGER: reg_rdata <= {31'h0, skip_cal_q};
				`SVC_REG_FEEDBACK: reg_rdata <= {16'h0, feedback_n_q};
				`SVC_REG_REFDIV: reg_rdata <= {19'h0, reference_doubler_q, 4'h0, ref_div_q};
				`SVC_REG_PUMP: reg_rdata <= {21'h0, pump_dly_q, 3'h0, gain_q};
				`SVC_REG_OSC: reg_rdata <= {8'h0, reference_rate_setting_q, band_start_code_q,
					5'h0, core_start_policy_q, core_select_q};
				`SVC_REG_OUTDIV: reg_rdata <= {21'h0, src_b_q, src_a_q, zero_delay_enable_q,
					2'h0, div_ratio_q};
				`SVC_REG_OUTPUT: reg_rdata <= {10'h0, level_b_q, 2'h0, level_a_q, 5'h0,
					override_q, pd_b_q, pd_a_q};
				`SVC_REG_STATUS: reg_rdata <= {14'h0, last_core_q, band_q, core_q, 3'h0,
					cal_fail_q, locked_q, cal_q != SVC_CAL_IDLE};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	cal_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cal_start |=> (cal_q == SVC_CAL_SETTLE && band_q == $past(band_start_code_q)))
		else $error("calibration did not start at band start code");
	cal_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_trig && reg_wdata[0] && cal_q == SVC_CAL_IDLE) |=> cal_q == SVC_CAL_IDLE)
		else $error("calibration ran with skip bit set");
	core_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cal_start && core_start_policy_q) |=> core_q == $past(core_select_q))
		else $error("wrong start core");
	last_core_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cal_q == SVC_CAL_DONE) |=> last_core_q == $past(core_q))
		else $error("last core not held");
	band_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cal_q == SVC_CAL_COMPARE && !at_s && above_s && band_q != 8'hFF && !cal_start)
		|=> band_q == $past(band_q) + 8'h01)
		else $error("band did not step toward lower frequency");
	zero_unlock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(zero_delay_enable_q) |-> !locked_q)
		else $error("zero delay enable kept lock");
	port_power_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		pd_a_q |=> !rf_port_a_on ##1 !rf_port_a_on || !$past(pd_a_q))
		else $error("powered-down port came up");
	level_a_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rf_port_a_on |-> rf_port_a_level == $past(level_a_q))
		else $error("level word not applied");
endmodule
`default_nettype wire

// *** verification/svc_osc_model.sv ***
// Oscillator and loop environment model facing the calibration logic
`default_nettype none
module svc_osc_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] core_active,
	input wire logic [7:0] band_active,
	input wire logic [10:0] target,
	output logic osc_tick,
	output logic osc_above_target,
	output logic osc_at_target
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] freq;
	// Higher core and lower band code both mean a faster oscillator
	assign freq = {1'b0, core_active, ~band_active};
	// A target beyond every core never locks, so exhaustion can be exercised
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_tick <= 1'b0;
			osc_above_target <= 1'b0;
			osc_at_target <= 1'b0;
		end else begin
			osc_tick <= ~osc_tick;
			osc_above_target <= freq > target;
			osc_at_target <= freq == target;
		end
	end
endmodule
`default_nettype wire

// *** verification/svc_synth_ctrl_tb.sv ***
// Self-checking testbench of the synthesizer control block
`include "svc_map.svh"
`default_nettype none
module svc_synth_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_n, reg_wr, reg_rd, ref_div_pulse, fb_div_pulse, output_gate_pin;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [10:0] tgt;
	logic osc_tick, osc_above_target, osc_at_target, pump_up, pump_down;
	logic [4:0] pump_gain_word;
	logic [1:0] core_active;
	logic [7:0] band_active;
	logic rf_port_a, rf_port_b, rf_port_a_on, rf_port_b_on, loop_locked, fb_through_divider;
	logic [5:0] rf_port_a_level, rf_port_b_level;
	logic on_e;
	logic pa;
	logic pb;
	int miscompares = 0;
	int n_tests = 0;
	int i;
	int k;
	int ca;
	int cb;
	logic [5:0] div_in [4] = '{6'h07, 6'h27, 6'h00, 6'h26};
	logic [5:0] div_ex [4] = '{6'h02, 6'h02, 6'h02, 6'h26};
	always #4 core_clk = ~core_clk;
	svc_synth_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse), .osc_tick(osc_tick),
		.osc_above_target(osc_above_target), .osc_at_target(osc_at_target),
		.output_gate_pin(output_gate_pin), .pump_up(pump_up), .pump_down(pump_down),
		.pump_gain_word(pump_gain_word), .core_active(core_active), .band_active(band_active),
		.rf_port_a(rf_port_a), .rf_port_b(rf_port_b), .rf_port_a_on(rf_port_a_on),
		.rf_port_b_on(rf_port_b_on), .rf_port_a_level(rf_port_a_level),
		.rf_port_b_level(rf_port_b_level), .loop_locked(loop_locked),
		.fb_through_divider(fb_through_divider));
	svc_osc_model osc (.core_clk(core_clk), .rst_n(rst_n), .core_active(core_active),
		.band_active(band_active), .target(tgt), .osc_tick(osc_tick),
		.osc_above_target(osc_above_target), .osc_at_target(osc_at_target));
	// ----------------------------------------
	// Access and check tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_cal();
		@(posedge core_clk);
		for (k = 0; k < 8000 && loop_locked !== 1'b1; k++) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_idle();
		d = 32'h1;
		for (k = 0; k < 4000 && d[0] !== 1'b0; k++) rd(`SVC_REG_STATUS, d);
	endtask
	task automatic step_done(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(8 * 40000);
		miscompares++;
		test_done();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		ref_div_pulse = 1'b0;
		fb_div_pulse = 1'b0;
		output_gate_pin = 1'b0;
		tgt = 11'h2CF;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk("core_active", core_active, 2'h2);
		chk("band_active", band_active, `SVC_RST_BAND);
		chk("fb_through_divider", fb_through_divider, 1'b0);
		step_done("reset");
		wr(`SVC_REG_PUMP, 32'h0000031F);
		#1 chk("pump_gain_word", pump_gain_word, 5'h1F);
		rd(`SVC_REG_PUMP, d);
		chk("pump_reg", d, 32'h0000031F);
		rd(4'h8, d);
		chk("unmapped", d, 32'h0);
		step_done("registers");
		for (i = 0; i < 4; i++) begin
			wr(`SVC_REG_OUTDIV, {26'h0, div_in[i]});
			rd(`SVC_REG_OUTDIV, d);
			chk("divide_ratio", d[5:0], div_ex[i]);
		end
		wr(`SVC_REG_OUTDIV, 32'h00000002);
		step_done("divider");
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk);
			output_gate_pin <= i[2];
			wr(`SVC_REG_OUTPUT, {10'h0, 6'h05, 2'h0, 6'h1E, 5'h0, i[1], 1'b1, i[0]});
			repeat (4) @(posedge core_clk);
			#1 on_e = !i[0] && (!i[1] || i[2]);
			chk("port_a_on", rf_port_a_on, on_e);
			chk("port_a_level", rf_port_a_level, on_e ? 6'h1E : 6'h00);
			chk("port_b_on", rf_port_b_on, 1'b0);
			chk("port_b_level", rf_port_b_level, 6'h00);
		end
		step_done("output power");
		// Port A runs through the divider at ratio 2, port B bypasses it
		wr(`SVC_REG_OUTPUT, 32'h00051E00);
		wr(`SVC_REG_OUTDIV, 32'h00000402);
		repeat (4) @(posedge core_clk);
		#1 pa = rf_port_a;
		pb = rf_port_b;
		ca = 0;
		cb = 0;
		repeat (32) begin
			@(posedge core_clk);
			#1 ca += int'(rf_port_a != pa);
			cb += int'(rf_port_b != pb);
			pa = rf_port_a;
			pb = rf_port_b;
		end
		chk("port_a_toggles", ca, 16);
		chk("port_b_toggles", cb, 32);
		chk("port_b_up", rf_port_b_on, 1'b1);
		chk("port_b_level_on", rf_port_b_level, 6'h05);
		step_done("rf ports");
		@(posedge core_clk);
		ref_div_pulse <= 1'b1;
		for (k = 0; k < 20 && pump_up !== 1'b1; k++) @(posedge core_clk);
		#1 chk("pump_up", pump_up, 1'b1);
		// Both directions stay on for the minimum pulse, then only the leading one
		chk("pump_min_on", pump_down, 1'b1);
		repeat (4) @(posedge core_clk);
		#1 chk("pump_down", pump_down, 1'b0);
		chk("pump_up_held", pump_up, 1'b1);
		@(posedge core_clk);
		fb_div_pulse <= 1'b1;
		for (k = 0; k < 40 && pump_up !== 1'b0; k++) @(posedge core_clk);
		#1 chk("pump_up_end", pump_up, 1'b0);
		// Doubler counts both reference edges, so R of 2 fires on one full pulse
		wr(`SVC_REG_REFDIV, 32'h00001002);
		@(posedge core_clk);
		ref_div_pulse <= 1'b0;
		repeat (4) @(posedge core_clk);
		ref_div_pulse <= 1'b1;
		for (k = 0; k < 20 && pump_up !== 1'b1; k++) @(posedge core_clk);
		#1 chk("doubled_ref", pump_up, 1'b1);
		step_done("phase detector");
		// Reference rate is programmed before the first calibration
		wr(`SVC_REG_OSC, 32'h00191004);
		wr(`SVC_REG_TRIGGER, 32'h0);
		@(posedge core_clk);
		#1 chk("start_core", core_active, 2'h0);
		chk("start_band", band_active, 8'h10);
		wait_cal();
		chk("cal_locked", loop_locked, 1'b1);
		chk("cal_core", core_active, 2'h2);
		chk("cal_band", band_active, 8'h30);
		step_done("calibration");
		// Small jump only, so starting from the last core is allowed
		tgt <= 11'h2D7;
		wr(`SVC_REG_OSC, 32'h00192000);
		wr(`SVC_REG_TRIGGER, 32'h0);
		@(posedge core_clk);
		#1 chk("last_core", core_active, 2'h2);
		chk("start_band2", band_active, 8'h20);
		wait_cal();
		chk("cal_band2", band_active, 8'h28);
		rd(`SVC_REG_STATUS, d);
		chk("last_core_reg", d[17:16], 2'h2);
		step_done("last core");
		wr(`SVC_REG_TRIGGER, 32'h1);
		rd(`SVC_REG_STATUS, d);
		chk("skip_busy", d[1:0], 2'h2);
		wr(`SVC_REG_OUTDIV, 32'h00000006);
		wr(`SVC_REG_OUTDIV, 32'h00000104);
		repeat (2) @(posedge core_clk);
		#1 chk("zd_unlock", loop_locked, 1'b0);
		chk("zd_path", fb_through_divider, 1'b1);
		wr(`SVC_REG_FEEDBACK, 32'h00000004);
		repeat (2) @(posedge core_clk);
		#1 chk("zd_relock", loop_locked, 1'b1);
		wr(`SVC_REG_OUTDIV, 32'h00000004);
		wr(`SVC_REG_TRIGGER, 32'h0);
		wait_cal();
		chk("recal_lock", loop_locked, 1'b1);
		step_done("zero delay");
		tgt <= 11'h400;
		wr(`SVC_REG_OSC, 32'h00191007);
		wr(`SVC_REG_TRIGGER, 32'h0);
		wait_idle();
		chk("fail_status", d, 32'h000300C4);
		step_done("exhausted search");
		test_done();
	end
endmodule
`default_nettype wire
